// ===== hw/pomc_top.v
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pomc_defs.vh"

module pomc_top (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // port output latches from the cpu
  input wire [7:0] port0_latch,
  input wire [7:0] port1_latch,
  input wire [1:0] port2_latch,
  // timer and clock sources
  input wire timer1_overflow,
  input wire rc_osc_used,
  input wire clk_out_src,
  // port 0 pads
  input wire [7:0] port0_pin_in,
  output wire [7:0] port0_pin_out,
  output wire [7:0] port0_pin_oe_n,
  output wire [7:0] port0_pullup,
  output wire port0_schmitt_enable,
  output reg [7:0] port0_in,
  // port 1 pads
  input wire [7:0] port1_pin_in,
  output wire [7:0] port1_pin_out,
  output wire [7:0] port1_pin_oe_n,
  output wire [7:0] port1_pullup,
  output wire port1_schmitt_enable,
  output reg [7:0] port1_in,
  // port 2 pads, pin 0 shared with the clock output
  input wire [1:0] port2_pin_in,
  output wire [1:0] port2_pin_out,
  output wire [1:0] port2_pin_oe_n,
  output wire [1:0] port2_pullup,
  output wire port2_schmitt_enable,
  output reg [1:0] port2_in
);

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  reg [7:0] port0_mode_low;
  reg [7:0] port0_mode_high;
  reg [7:0] port1_mode_low;
  reg [7:0] port1_mode_high;
  reg [7:0] port2_mode_low_misc;
  reg [7:0] port2_mode_high;
  reg toggle_a;
  reg toggle_b;
  reg [7:0] sync0_a;
  reg [7:0] sync1_a;
  reg [1:0] sync2_a;

  wire clock_output_enable;
  wire timer_toggle_out_a_enable;
  wire timer_toggle_out_b_enable;
  wire [7:0] p0_value;
  wire [7:0] p1_value;
  wire [1:0] p2_value;
  wire [7:0] p1_low_eff;
  wire [7:0] p1_high_eff;
  wire clk_out_active;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port0_mode_low <= `POMC_RST_MODE;
      port0_mode_high <= `POMC_RST_MODE;
      port1_mode_low <= `POMC_RST_MODE;
      port1_mode_high <= `POMC_RST_MODE;
      port2_mode_low_misc <= `POMC_RST_MODE;
      port2_mode_high <= `POMC_RST_MODE;
    end else if (reg_wr) begin
      case (reg_addr)
        `POMC_ADDR_P0_LOW: begin
          port0_mode_low <= reg_wdata;
        end
        `POMC_ADDR_P0_HIGH: begin
          port0_mode_high <= reg_wdata;
        end
        `POMC_ADDR_P1_LOW: begin
          port1_mode_low <= reg_wdata & `POMC_P1_IMPL_MASK;
        end
        `POMC_ADDR_P1_HIGH: begin
          port1_mode_high <= reg_wdata & `POMC_P1_IMPL_MASK;
        end
        `POMC_ADDR_P2_LOW: begin
          port2_mode_low_misc <= reg_wdata;
        end
        `POMC_ADDR_P2_HIGH: begin
          port2_mode_high <= reg_wdata & `POMC_P2_MODE_MASK;
        end
        default: begin
          port0_mode_low <= port0_mode_low;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read back, one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `POMC_ADDR_P0_LOW: reg_rdata <= port0_mode_low;
        `POMC_ADDR_P0_HIGH: reg_rdata <= port0_mode_high;
        `POMC_ADDR_P1_LOW: reg_rdata <= port1_mode_low;
        `POMC_ADDR_P1_HIGH: reg_rdata <= port1_mode_high;
        `POMC_ADDR_P2_LOW: reg_rdata <= port2_mode_low_misc;
        `POMC_ADDR_P2_HIGH: reg_rdata <= port2_mode_high;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  // schmitt, clock output and toggle enables
  assign port2_schmitt_enable = port2_mode_low_misc[`POMC_BIT_P2_SCHMITT];
  assign port1_schmitt_enable = port1_mode_low_misc_bit(1'b0);
  assign port0_schmitt_enable = port2_mode_low_misc[`POMC_BIT_P0_SCHMITT];
  assign clock_output_enable = port2_mode_low_misc[`POMC_BIT_CLK_OUT];
  assign timer_toggle_out_a_enable = port2_mode_low_misc[`POMC_BIT_TOGGLE_A];
  assign timer_toggle_out_b_enable = port2_mode_low_misc[`POMC_BIT_TOGGLE_B];

  function port1_mode_low_misc_bit;
    input dummy;
    begin
      port1_mode_low_misc_bit =
        port2_mode_low_misc[`POMC_BIT_P1_SCHMITT] | (dummy & 1'b0);
    end
  endfunction

  // ----------------------------------------
  // timer toggle outputs
  // ----------------------------------------
  // overflow comes from the timer on this clock, so it is not synchronised
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_a <= 1'b1;
      toggle_b <= 1'b1;
    end else begin
      if (timer1_overflow && timer_toggle_out_a_enable) begin
        toggle_a <= ~toggle_a;
      end
      if (timer1_overflow && timer_toggle_out_b_enable) begin
        toggle_b <= ~toggle_b;
      end
    end
  end

  // ----------------------------------------
  // pin values
  // ----------------------------------------
  // toggle replaces latch
  assign p0_value = {timer_toggle_out_a_enable ? toggle_a : port0_latch[7],
                     port0_latch[6:0]};
  assign p1_value = {port1_latch[7:3],
                     timer_toggle_out_b_enable ? toggle_b : port1_latch[2],
                     port1_latch[1:0]};
  assign clk_out_active = clock_output_enable & rc_osc_used;
  assign p2_value = {port2_latch[1],
                     clk_out_active ? clk_out_src : port2_latch[0]};

  assign p1_low_eff = port1_mode_low & `POMC_P1_IMPL_MASK;
  assign p1_high_eff = port1_mode_high & `POMC_P1_IMPL_MASK;

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p01
      pomc_pin_drv u_p0 (
        .mode_low(port0_mode_low[gi]),
        .mode_high(port0_mode_high[gi]),
        .out_value(p0_value[gi]),
        .pad_out(port0_pin_out[gi]),
        .pad_oe_n(port0_pin_oe_n[gi]),
        .pad_pullup(port0_pullup[gi])
      );
      pomc_pin_drv u_p1 (
        .mode_low(p1_low_eff[gi]),
        .mode_high(p1_high_eff[gi]),
        .out_value(p1_value[gi]),
        .pad_out(port1_pin_out[gi]),
        .pad_oe_n(port1_pin_oe_n[gi]),
        .pad_pullup(port1_pullup[gi])
      );
    end
    // port 2 pins 1 and 0
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_p2
      pomc_pin_drv u_p2 (
        .mode_low(port2_mode_low_misc[gi]),
        .mode_high(port2_mode_high[gi]),
        .out_value(p2_value[gi]),
        .pad_out(port2_pin_out[gi]),
        .pad_oe_n(port2_pin_oe_n[gi]),
        .pad_pullup(port2_pullup[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // pins are asynchronous; two stages before anything reads them
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync0_a <= 8'h00;
      sync1_a <= 8'h00;
      sync2_a <= 2'h0;
      port0_in <= 8'h00;
      port1_in <= 8'h00;
      port2_in <= 2'h0;
    end else begin
      sync0_a <= port0_pin_in;
      sync1_a <= port1_pin_in;
      sync2_a <= port2_pin_in;
      port0_in <= sync0_a;
      port1_in <= sync1_a;
      port2_in <= sync2_a;
    end
  end

endmodule

`default_nettype wire

// ===== inc/pomc_defs.vh
`ifndef POMC_DEFS_VH
`define POMC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define POMC_ADDR_P0_LOW 8'hB1
`define POMC_ADDR_P0_HIGH 8'hB2
`define POMC_ADDR_P1_LOW 8'hB3
`define POMC_ADDR_P1_HIGH 8'hB4
`define POMC_ADDR_P2_LOW 8'hB5
`define POMC_ADDR_P2_HIGH 8'hB6

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define POMC_BIT_P2_SCHMITT 7
`define POMC_BIT_P1_SCHMITT 6
`define POMC_BIT_P0_SCHMITT 5
`define POMC_BIT_CLK_OUT 4
`define POMC_BIT_TOGGLE_A 3
`define POMC_BIT_TOGGLE_B 2
`define POMC_P1_IMPL_MASK 8'hD3
`define POMC_P2_MODE_MASK 8'h03

// ----------------------------------------
// reset values
// ----------------------------------------
`define POMC_RST_MODE 8'h00

// ----------------------------------------
// mode encodings {mode_low, mode_high}
// ----------------------------------------
`define POMC_MODE_QUASI 2'h0
`define POMC_MODE_PUSH 2'h1
`define POMC_MODE_INPUT 2'h2
`define POMC_MODE_OPEN 2'h3

`endif

// ===== hw/pomc_pin_drv.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// one pin driver: mode decode and pad enables
// ----------------------------------------
module pomc_pin_drv (
  // mode select
  input wire mode_low,
  input wire mode_high,
  // value to drive
  input wire out_value,
  // pad controls, enable active low
  output reg pad_out,
  output reg pad_oe_n,
  output reg pad_pullup
);

  always @* begin
    pad_out = out_value;
    pad_oe_n = 1'b1;
    pad_pullup = 1'b0;
    case ({mode_low, mode_high})
      2'b00: begin
        pad_out = 1'b0;
        pad_oe_n = out_value;
        pad_pullup = out_value;
      end
      2'b01: begin
        pad_oe_n = 1'b0;
      end
      2'b10: begin
        pad_oe_n = 1'b1;
      end
      2'b11: begin
        pad_out = 1'b0;
        pad_oe_n = out_value;
      end
      default: begin
        pad_oe_n = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== bench/pomc_pads.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pad and board model
// ----------------------------------------
// every pin has a board pull-down; the on-chip pull-up beats it, so a
// released pin never floats to a value the simulator picks
module pomc_pads #(parameter W = 8) (
  // pad controls from the block
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull_en,
  // resolved level back to the block
  output logic [W-1:0] level
);
  assign level = (~oe_n & pin_out) | (oe_n & pull_en);
endmodule
`default_nettype wire

// ===== bench/pomc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port mode checker
// ----------------------------------------
module pomc_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // sources
  input wire logic timer1_overflow,
  input wire logic rc_osc_used,
  input wire logic clk_out_src,
  input wire logic [1:0] port2_latch,
  // pads
  input wire logic [7:0] port0_pin_out,
  input wire logic [7:0] port0_pin_oe_n,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe_n,
  input wire logic [1:0] port2_pin_out,
  input wire logic [1:0] port2_pin_oe_n,
  input wire logic port0_schmitt_enable,
  input wire logic port1_schmitt_enable,
  input wire logic port2_schmitt_enable
);
  logic [4:0] b5;
  logic [1:0] b6;
  wire logic [1:0] m1 = {b5[1], b6[1]};
  // driven value shows as oe_n xor pin_out in every driving mode
  wire logic v0 = port0_pin_oe_n[7] ^ port0_pin_out[7];
  wire logic v1 = port1_pin_oe_n[2] ^ port1_pin_out[2];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      b5 <= 5'h00;
      b6 <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'hB5) b5 <= reg_wdata[4:0];
      if (reg_addr == 8'hB6) b6 <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  p1_mask_a: assert property (
    reg_rd && reg_addr == 8'hB3 |=> (reg_rdata & 8'h2C) == 8'h00)
    else $error("port1 unused bits read set");
  p2_mask_a: assert property (
    reg_rd && reg_addr == 8'hB6 |=> reg_rdata[7:2] == 6'h00)
    else $error("port2 upper mode bits read set");
  schmitt_en_a: assert property (
    reg_wr && reg_addr == 8'hB5 |=> {port2_schmitt_enable,
    port1_schmitt_enable, port0_schmitt_enable} == $past(reg_wdata[7:5]))
    else $error("schmitt enables wrong");
  tog_p0_a: assert property (
    b5[3] && timer1_overflow && !reg_wr && !port0_pin_oe_n[7]
    |=> v0 != $past(v0)) else $error("port0 pin7 missed toggle");
  tog_p1_a: assert property (
    b5[2] && timer1_overflow && !reg_wr && !port1_pin_oe_n[2]
    |=> v1 != $past(v1)) else $error("port1 pin2 missed toggle");
  clk_out_a: assert property (
    b5[4] && rc_osc_used && !port2_pin_oe_n[0] |->
    port2_pin_out[0] == clk_out_src) else $error("clock out missing");
  quasi_open_a: assert property (
    m1 == 2'h0 || m1 == 2'h3 |-> !port2_pin_out[1] &&
    port2_pin_oe_n[1] == port2_latch[1]) else $error("weak mode wrong");
  push_pull_a: assert property (
    m1 == 2'h1 |-> !port2_pin_oe_n[1] && port2_pin_out[1] == port2_latch[1])
    else $error("push-pull mode wrong");
  input_only_a: assert property (
    m1 == 2'h2 |-> port2_pin_oe_n[1]) else $error("input pin driven");
endmodule
bind pomc_top pomc_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer1_overflow(timer1_overflow), .rc_osc_used(rc_osc_used),
  .clk_out_src(clk_out_src), .port2_latch(port2_latch),
  .port0_pin_out(port0_pin_out), .port0_pin_oe_n(port0_pin_oe_n),
  .port1_pin_out(port1_pin_out), .port1_pin_oe_n(port1_pin_oe_n),
  .port2_pin_out(port2_pin_out), .port2_pin_oe_n(port2_pin_oe_n),
  .port0_schmitt_enable(port0_schmitt_enable),
  .port1_schmitt_enable(port1_schmitt_enable),
  .port2_schmitt_enable(port2_schmitt_enable));
`default_nettype wire

// ===== bench/pomc_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
// ----------------------------------------
// mode block bench
// ----------------------------------------
module testbench;
  logic clk = 0, sys_rst = 1, wr = 0, rd = 0, tov = 0, rc = 0, cs = 0;
  logic [7:0] adr = 0, wd = 0, rdat, o0, e0, u0, o1, e1, u1, p0, p1;
  logic [7:0] i0, i1, l0 = 0, l1 = 0;
  logic [7:0] msk [6] = '{8'hFF, 8'hFF, 8'hD3, 8'hD3, 8'hFF, 8'h03};
  logic [1:0] l2 = 0, o2, e2, u2, i2, p2;
  logic [1:0] eo [4] = '{2'h2, 2'h0, 2'h3, 2'h2};
  logic [1:0] ei [4] = '{2'h2, 2'h2, 2'h0, 2'h0};
  logic s0, s1, s2;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  wire logic [1:0] tg = {e0[7] ^ o0[7], e1[2] ^ o1[2]};
  pomc_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(adr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .port0_latch(l0), .port1_latch(l1), .port2_latch(l2),
    .timer1_overflow(tov), .rc_osc_used(rc), .clk_out_src(cs),
    .port0_pin_in(p0), .port0_pin_out(o0), .port0_pin_oe_n(e0),
    .port0_pullup(u0), .port0_schmitt_enable(s0), .port0_in(i0),
    .port1_pin_in(p1), .port1_pin_out(o1), .port1_pin_oe_n(e1),
    .port1_pullup(u1), .port1_schmitt_enable(s1), .port1_in(i1),
    .port2_pin_in(p2), .port2_pin_out(o2), .port2_pin_oe_n(e2),
    .port2_pullup(u2), .port2_schmitt_enable(s2), .port2_in(i2));
  pomc_pads pad0 (.pin_out(o0), .oe_n(e0), .pull_en(u0), .level(p0));
  pomc_pads pad1 (.pin_out(o1), .oe_n(e1), .pull_en(u1), .level(p1));
  pomc_pads #(.W(2)) pad2 (.pin_out(o2), .oe_n(e2), .pull_en(u2), .level(p2));
  initial begin
    forever #5 clk = ~clk;
  end
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task bw(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task br(input logic [7:0] a, e);
    @(posedge clk);
    rd <= 1;
    adr <= a;
    @(posedge clk);
    rd <= 0;
    #1 `CHK("rdata", e, rdat)
  endtask
  task pulse(input int n);
    @(posedge clk);
    tov <= 1;
    repeat (n) @(posedge clk);
    tov <= 0;
    @(posedge clk);
    #1;
  endtask
  task t_regs;
    int i;
    for (i = 0; i < 6; i++) br(8'hB1 + 8'(i), 8'h00);
    for (i = 0; i < 6; i++) bw(8'hB1 + 8'(i), 8'hFF);
    for (i = 0; i < 6; i++) br(8'hB1 + 8'(i), msk[i]);
    bw(8'hB7, 8'hFF);
    br(8'hB7, 8'h00);
  endtask
  task t_schm;
    int i;
    for (i = 0; i < 3; i++) begin
      bw(8'hB5, 8'h20 << i);
      #1 `CHK("schmitt", 3'h1 << i, {s2, s1, s0})
    end
  endtask
  // every mode on port 2, latch 10, so each mode leaves its own mark
  task t_modes;
    int i;
    @(posedge clk);
    l2 <= 2'h2;
    for (i = 0; i < 4; i++) begin
      bw(8'hB5, {6'h00, {2{i[1]}}});
      bw(8'hB6, {6'h00, {2{i[0]}}});
      repeat (4) @(posedge clk);
      #1 `CHK("oe_n", eo[i], e2)
      `CHK("level", ei[i], i2)
    end
  endtask
  // toggle flops leave reset at 1; latches at 0 so the toggle shows
  task t_tog;
    int i;
    for (i = 0; i < 4; i++) bw(8'hB1 + 8'(i), 8'h00);
    bw(8'hB5, 8'h0C);
    #1 `CHK("toggle init", 2'h3, tg)
    pulse(1);
    `CHK("toggle", 2'h0, tg)
    pulse(2);
    `CHK("toggle twice", 2'h0, tg)
    bw(8'hB5, 8'h00);
    l0 <= 8'h80;
    l1 <= 8'h04;
    #1 `CHK("latch back", 2'h3, tg)
    pulse(1);
    `CHK("toggle off", 2'h3, tg)
  endtask
  // port 0 push-pull, port 1 open drain with its unused pins quasi
  task t_ports;
    bw(8'hB1, 8'h00);
    bw(8'hB2, 8'hFF);
    bw(8'hB3, 8'hFF);
    bw(8'hB4, 8'hFF);
    l0 <= 8'hA5;
    l1 <= 8'hFF;
    repeat (4) @(posedge clk);
    #1 `CHK("port0 level", 8'hA5, i0)
    `CHK("port1 level", 8'h2C, i1)
  endtask
  task t_clk;
    bw(8'hB6, 8'h01);
    bw(8'hB5, 8'h10);
    rc <= 1;
    repeat (4) begin
      @(posedge clk);
      cs <= ~cs;
      #1 `CHK("clk out", cs, o2[0])
    end
    @(posedge clk);
    rc <= 0;
    cs <= 1;
    #1 `CHK("no clk out", 1'b0, o2[0])
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    t_regs;
    t_schm;
    t_modes;
    t_tog;
    t_clk;
    t_ports;
    tally_and_finish;
  end
endmodule
`default_nettype wire
